/* sim/basic_mode_control_tb.sv */
/* bench of the control block; assumes mgmt_sme and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module basic_mode_control_tb;
    import bmc_pkg::*;
    logic clk_in = 1'h0, rst_in = 1'h1, ref_clk_25mhz_in = 1'h0, rs = 1'h0;
    logic tx_er_in = 1'h0, an_started_in = 1'h0, an_full_duplex_in = 1'h1;
    logic an_speed_100_in = 1'h1, core_col_in = 1'h0, tx_en_in = 1'h0;
    logic mgmt_wr_in, an_restart_out, an_enable_out, speed_100_out, col_out;
    logic full_duplex_out, loopback_out, power_down_out, soft_reset_out;
    logic ref_clock_25mhz_out, core_tx_en_out, core_tx_er_out, mii_out_oe_out;
    phy_addr_t strapped_phy_address_in = 5'h03, mgmt_addr_in;
    nibble_t txd_in = 4'h0, core_txd_out;
    reg_word_t mgmt_wdata_in, mgmt_rdata_out, d;
    int err_total = 0, checked = 0;
    basic_mode_control dut (.*);
    mgmt_sme sme (.clk_in, .a_out(mgmt_addr_in), .w_out(mgmt_wr_in),
        .d_out(mgmt_wdata_in));
    always #5 clk_in = ~clk_in;
    always #20 ref_clk_25mhz_in = ~ref_clk_25mhz_in;
    task chk(input reg_word_t g, input reg_word_t e);
        checked++;
        if (g !== e)
            $display("[ERR] %0t got %h want %h", $time, g, e);
        err_total += int'(g !== e);
    endtask : chk
    function automatic reg_word_t ew(reg_word_t w);
        return {1'b0, w[14:10], rs, w[12] ? an_full_duplex_in : w[8], w[7],
            7'h00};
    endfunction : ew
    task reset_run;
        rst_in = 1'h1;
        repeat (8) @(negedge clk_in);
        rst_in = 1'h0;
        repeat (3) @(negedge clk_in);
    endtask : reset_run
    task complete_run;
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        void'($urandom(32'h10159410));
        reset_run();
        chk(mgmt_rdata_out, 16'h3100);
        repeat (30)
        begin
            d = 16'($urandom) & 16'h7fff;
            {tx_er_in, an_started_in, an_full_duplex_in, an_speed_100_in,
                tx_en_in, txd_in} = 9'($urandom);
            rs = d[12] && !an_started_in && (rs || d[9]);
            sme.put(5'h00, d);
            sme.put(5'h01, ~d);
            repeat (3) @(negedge clk_in);
            chk(mgmt_rdata_out, ew(d));
            chk(16'({mii_out_oe_out, power_down_out, loopback_out, col_out,
                speed_100_out, full_duplex_out, core_tx_er_out,
                core_tx_en_out, core_txd_out}), 16'({!d[10], d[11], d[14],
                d[7] && tx_er_in, d[12] ? an_speed_100_in : d[13],
                d[12] ? an_full_duplex_in : d[8], d[10] ? 6'h00 :
                {tx_er_in, tx_en_in, txd_in}}));
        end
        {tx_er_in, an_full_duplex_in} = 2'h3;
        sme.put(5'h00, 16'h0080);
        repeat (5) @(negedge clk_in);
        chk(16'(col_out), 16'h0001);
        sme.put(5'h00, 16'h8000);
        @(negedge clk_in);
        chk(16'(mgmt_rdata_out[15]), 16'h0001);
        repeat (7) @(negedge clk_in);
        chk(mgmt_rdata_out, 16'h3100);
        strapped_phy_address_in = 5'h00;
        reset_run();
        chk(mgmt_rdata_out, 16'h3500);
        chk(16'({mii_out_oe_out, ref_clock_25mhz_out}),
            16'({1'b0, ref_clk_25mhz_in}));
        complete_run();
    end
endmodule : basic_mode_control_tb
`default_nettype wire

/* sim/bmc_chk.sv */
/* port assertions of the control block; bound to it below. */
`timescale 1ns/1ps
`default_nettype none
module bmc_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [4:0] mgmt_addr_in,
    input wire logic mgmt_wr_in,
    input wire logic [15:0] mgmt_wdata_in,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic an_started_in,
    input wire logic an_speed_100_in,
    input wire logic an_restart_out,
    input wire logic an_enable_out,
    input wire logic speed_100_out,
    input wire logic full_duplex_out,
    input wire logic soft_reset_out,
    input wire logic tx_er_in,
    input wire logic col_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic wr = mgmt_wr_in && mgmt_addr_in == 5'h00 && !soft_reset_out;
    wire logic w1 = wr && !mgmt_wdata_in[15];
    wire logic w2 = w1 && mgmt_wdata_in[12];
    restart_set_a: assert property (w2 && mgmt_wdata_in[9]
        |=> an_restart_out) else $error("restart not set");
    ack_clear_a: assert property (an_started_in && !mgmt_wr_in
        |=> !an_restart_out) else $error("restart not cleared");
    restart_off_a: assert property (w1 && !mgmt_wdata_in[12]
        |=> !an_restart_out) else $error("restart while off");
    restart_hold_a: assert property (w2 && an_restart_out
        && !an_started_in |=> an_restart_out) else $error("restart lost");
    soft_run_a: assert property (wr && mgmt_wdata_in[15]
        |=> soft_reset_out [*4] ##1 !soft_reset_out)
        else $error("soft reset length");
    col_test_a: assert property ((tx_er_in && mgmt_rdata_out[7]
        && !mgmt_rdata_out[10]) [*4] |-> col_out) else $error("no col");
    forced_mode_a: assert property ((!an_enable_out && !mgmt_wr_in
        && !soft_reset_out) [*3] |-> speed_100_out == mgmt_rdata_out[13]
        && full_duplex_out == mgmt_rdata_out[8]) else $error("forced mode");
    neg_mode_a: assert property ((an_enable_out
        && $stable(an_speed_100_in)) [*3] |-> speed_100_out
        == an_speed_100_in) else $error("negotiated speed");
endmodule : bmc_chk
bind basic_mode_control bmc_chk u_chk (.*);
`default_nettype wire

/* sim/mgmt_sme.sv */
/* management station; assumes the bench calls put between checks. */
`timescale 1ns/1ps
`default_nettype none
module mgmt_sme (
    input wire logic clk_in,
    output logic [4:0] a_out,
    output logic w_out,
    output logic [15:0] d_out
);
    initial {a_out, w_out, d_out} = '0;
    task put(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_in);
        a_out = a;
        d_out = {d[15:10], d[9] & d[12], d[8:7], 7'h00};
        w_out = 1'b1;
        @(negedge clk_in);
        w_out = 1'b0;
        d_out = ~d_out;
    endtask : put
endmodule : mgmt_sme
`default_nettype wire

/* src/basic_mode_control.sv */
/*
 * basic mode control register, bits 15..0, with isolation of the mii and
 * collision test. assumes a serial management engine on clk_in that
 * presents one-cycle write strobes with a register address, and an
 * auto-negotiation engine that acknowledges a restart when it begins.
 * mii inputs arrive asynchronously and are synchronised here.
 */
// How it works
// - with negotiation off, speed bit picks 100 or 10 Mb/s
// - negotiation enable makes speed and duplex bits ignored
// - power-down bit stored read/write, no effect on operation
// - while isolated, transmit data and enable inputs are ignored; the tx error input still drives the collision test
// - while isolated, all mii outputs are released to high impedance
// - while isolated, reference clock and management access keep working
// - isolate bit set at reset when strapped address is 00000
// - writing restart 1 restarts negotiation; reads 1 until begun
// - restart has no effect while negotiation is disabled
// - writing restart 0 never aborts negotiation in progress
// - with negotiation off, duplex bit picks full or half
// - with negotiation on, duplex reads the negotiated capability
// - collision test drives col whenever tx error is asserted
// - reserved bits 6..0 written as zero, read as zero
// - software reset restores defaults, reads 1 until complete
`include "bmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module basic_mode_control
    import bmc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [4:0] strapped_phy_address_in,
    input wire logic [4:0] mgmt_addr_in,
    input wire logic mgmt_wr_in,
    input wire logic [15:0] mgmt_wdata_in,
    output logic [15:0] mgmt_rdata_out,
    input wire logic an_started_in,
    input wire logic an_full_duplex_in,
    input wire logic an_speed_100_in,
    output logic an_restart_out,
    output logic an_enable_out,
    output logic speed_100_out,
    output logic full_duplex_out,
    output logic loopback_out,
    output logic power_down_out,
    output logic soft_reset_out,
    input wire logic ref_clk_25mhz_in,
    output logic ref_clock_25mhz_out,
    input wire logic [3:0] txd_in,
    input wire logic tx_en_in,
    input wire logic tx_er_in,
    output logic [3:0] core_txd_out,
    output logic core_tx_en_out,
    output logic core_tx_er_out,
    input wire logic core_col_in,
    output logic col_out,
    output logic mii_out_oe_out
);
    logic [5:0] tx_meta_reg;
    logic [5:0] tx_sync_reg;
    logic [4:0] strap_meta_reg;
    logic [4:0] strap_sync_reg;
    logic speed_reg;
    logic an_en_reg;
    logic pdown_reg;
    logic isolate_reg;
    logic restart_reg;
    logic duplex_reg;
    logic coltest_reg;
    logic loop_reg;
    logic [3:0] srst_cnt_reg;
    logic [3:0] srst_cnt_next;
    logic strap_load_reg;
    logic col_reg;
    logic wr_hit;
    logic srst_req;
    logic srst_busy;
    logic defaults_load;

    assign wr_hit = mgmt_wr_in && (mgmt_addr_in == `BMC_ADDR);
    assign srst_req = wr_hit && mgmt_wdata_in[`BMC_BIT_RESET] && !srst_busy;
    assign srst_busy = (srst_cnt_reg != 4'h0);
    assign defaults_load = rst_in || srst_busy;

    // strap pins pass two flops before the compare
    always_ff @(posedge clk_in)
    begin
        strap_meta_reg <= strapped_phy_address_in;
        strap_sync_reg <= strap_meta_reg;
    end

    // two-stage synchroniser for mii transmit inputs
    always_ff @(posedge clk_in)
    begin
        tx_meta_reg <= {tx_er_in, tx_en_in, txd_in};
        tx_sync_reg <= tx_meta_reg;
    end

    // software reset duration
    always_comb
    begin
        srst_cnt_next = srst_cnt_reg;
        if (srst_req)
            srst_cnt_next = `SOFT_RESET_CYCLES;
        else if (srst_busy)
            srst_cnt_next = srst_cnt_reg - 4'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            srst_cnt_reg <= 4'h0;
        else
            srst_cnt_reg <= srst_cnt_next;
    end

    // strap is caught on the first edge after reset
    always_ff @(posedge clk_in)
    begin
        if (defaults_load)
            strap_load_reg <= 1'b1;
        else
            strap_load_reg <= 1'b0;
    end

    // control bits
    always_ff @(posedge clk_in)
    begin
        if (defaults_load)
        begin
            speed_reg <= `BMC_DEF_SPEED;
            an_en_reg <= `BMC_DEF_AN_EN;
            pdown_reg <= `BMC_DEF_PDOWN;
            duplex_reg <= `BMC_DEF_DUPLEX;
            coltest_reg <= `BMC_DEF_COLTEST;
            loop_reg <= `BMC_DEF_LOOPBACK;
        end
        else if (wr_hit && !srst_req)
        begin
            speed_reg <= mgmt_wdata_in[`BMC_BIT_SPEED];
            an_en_reg <= mgmt_wdata_in[`BMC_BIT_AN_EN];
            pdown_reg <= mgmt_wdata_in[`BMC_BIT_PDOWN];
            duplex_reg <= mgmt_wdata_in[`BMC_BIT_DUPLEX];
            coltest_reg <= mgmt_wdata_in[`BMC_BIT_COLTEST];
            loop_reg <= mgmt_wdata_in[`BMC_BIT_LOOPBACK];
        end
    end

    // isolate bit, strapped at reset
    always_ff @(posedge clk_in)
    begin
        if (defaults_load)
            isolate_reg <= 1'b0;
        else if (strap_load_reg)
            isolate_reg <= (strap_sync_reg == `BMC_ISOLATE_ADDR);
        else if (wr_hit && !srst_req)
            isolate_reg <= mgmt_wdata_in[`BMC_BIT_ISOLATE];
    end

    // restart: self clearing, set wins over the acknowledge
    always_ff @(posedge clk_in)
    begin
        if (defaults_load)
            restart_reg <= `BMC_DEF_AN_RESTART;
        else if (wr_hit && !srst_req && mgmt_wdata_in[`BMC_BIT_AN_EN]
                 && mgmt_wdata_in[`BMC_BIT_AN_RESTART])
            restart_reg <= 1'b1;
        else if (an_started_in || !an_en_reg
                 || (wr_hit && !mgmt_wdata_in[`BMC_BIT_AN_EN]))
            restart_reg <= 1'b0;
        // a written 0 with the enable bit written 1 leaves a pending restart in place
    end

    // effective mode
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            speed_100_out <= 1'b0;
            full_duplex_out <= 1'b0;
        end
        else if (an_en_reg)
        begin
            speed_100_out <= an_speed_100_in;
            full_duplex_out <= an_full_duplex_in;
        end
        else
        begin
            speed_100_out <= speed_reg;
            full_duplex_out <= duplex_reg;
        end
    end

    // transmit path into the core, blocked while isolated
    always_ff @(posedge clk_in)
    begin
        if (rst_in || isolate_reg)
        begin
            core_txd_out <= 4'h0;
            core_tx_en_out <= 1'b0;
            core_tx_er_out <= 1'b0;
        end
        else
        begin
            core_txd_out <= tx_sync_reg[3:0];
            core_tx_en_out <= tx_sync_reg[4];
            core_tx_er_out <= tx_sync_reg[5];
        end
    end

    // collision output with test mode
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            col_reg <= 1'b0;
        else
            col_reg <= core_col_in
                || (coltest_reg && tx_sync_reg[5]);
    end

    assign col_out = col_reg;
    assign mii_out_oe_out = !isolate_reg;
    assign ref_clock_25mhz_out = ref_clk_25mhz_in;
    assign an_restart_out = restart_reg;
    assign an_enable_out = an_en_reg;
    assign loopback_out = loop_reg;
    assign power_down_out = pdown_reg;
    assign soft_reset_out = srst_busy;

    // read data; reserved bits read zero
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            mgmt_rdata_out <= 16'h0000;
        else
            mgmt_rdata_out <= {srst_busy, loop_reg, speed_reg, an_en_reg,
                pdown_reg, isolate_reg, restart_reg,
                an_en_reg ? an_full_duplex_in : duplex_reg,
                coltest_reg, 7'h00};
    end
endmodule : basic_mode_control

`default_nettype wire

/* src/bmc_cfg.svh */
/*
 * constants of the basic mode control register: address, bit positions,
 * defaults. assumes inclusion by the control module.
 */
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH

`define BMC_ADDR 5'h00
`define BMC_BIT_RESET 15
`define BMC_BIT_LOOPBACK 14
`define BMC_BIT_SPEED 13
`define BMC_BIT_AN_EN 12
`define BMC_BIT_PDOWN 11
`define BMC_BIT_ISOLATE 10
`define BMC_BIT_AN_RESTART 9
`define BMC_BIT_DUPLEX 8
`define BMC_BIT_COLTEST 7
`define BMC_DEF_SPEED 1'b1
`define BMC_DEF_AN_EN 1'b1
`define BMC_DEF_PDOWN 1'b0
`define BMC_DEF_AN_RESTART 1'b0
`define BMC_DEF_DUPLEX 1'b1
`define BMC_DEF_COLTEST 1'b0
`define BMC_DEF_LOOPBACK 1'b0
`define BMC_ISOLATE_ADDR 5'h00
`define SOFT_RESET_CYCLES 4'h4

`endif

/* src/bmc_pkg.sv */
/*
 * types of the basic mode control register block.
 * assumes nothing beyond the cfg header.
 */
package bmc_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [4:0] phy_addr_t;
    typedef logic [3:0] nibble_t;
endpackage : bmc_pkg
